// ==== logic/dssp_top.sv ====
// Purpose: Pair of synchronous serial ports with framing and companding; multichannel on port zero only
// Assumes: Link pins come from outside the clock domain; link clock well below clk_i/4
// Notes: Port one can hand its pins to interrupt and flag functions at any time
`timescale 1ns/1ps
module dssp_top import dssp_pkg::*; (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire dssp_cfg_t [PORTS-1:0] cfg_i,
	input wire dssp_pin_in_t [PORTS-1:0] pin_i,
	output dssp_pin_out_t [PORTS-1:0] pin_o,
	input wire logic [PORTS-1:0] tx_valid_i,
	input wire logic [PORTS-1:0][WORD_W-1:0] tx_data_i,
	output logic [PORTS-1:0] tx_ready_o,
	output logic [PORTS-1:0] rx_valid_o,
	output logic [PORTS-1:0][WORD_W-1:0] rx_data_o,
	input wire logic [PORTS-1:0] rx_ready_i,
	output logic [PORTS-1:0] rx_irq_o,
	output logic [PORTS-1:0] tx_irq_o,
	output logic [PORTS-1:0] rx_overrun_o,
	input wire logic mc_en_i,
	input wire logic mc_32_i,
	input wire logic [31:0] mc_rx_mask_i,
	input wire logic [31:0] mc_tx_mask_i,
	input wire logic p1_alt_i,
	input wire logic flag_output_i,
	output logic ext_interrupt_a_o,
	output logic ext_interrupt_b_o,
	output logic flag_input_o
);
	dssp_pin_in_t [PORTS-1:0] s1_q;
	dssp_pin_in_t [PORTS-1:0] s2_q;
	logic [PORTS-1:0] sck_s3_q;
	logic flag_out_q;

	// Two-stage synchronisers on every link input
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) sck_s3_q <= '0;
		else begin
			for (int k = 0; k < PORTS; k++) begin
				sck_s3_q[k] <= s2_q[k].sclk;
			end
		end
	end

	// Port one alternate pin functions, switchable at run time
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ext_interrupt_a_o <= 1'b0;
			ext_interrupt_b_o <= 1'b0;
			flag_input_o <= 1'b0;
			flag_out_q <= 1'b0;
		end else begin
			ext_interrupt_a_o <= p1_alt_i && s2_q[1].rfs;
			ext_interrupt_b_o <= p1_alt_i && s2_q[1].tfs;
			flag_input_o <= p1_alt_i && s2_q[1].dr;
			flag_out_q <= flag_output_i;
		end
	end

	for (genvar p = 0; p < PORTS; p++) begin : g_port
		dssp_cfg_t c;
		logic alt;
		logic en;
		logic mc;
		logic [DIV_W-1:0] dcnt_q;
		logic sck_q;
		logic tick;
		logic rise;
		logic fall;
		logic [3:0] slen;
		logic [15:0] mask;
		logic rfs_seen;
		logic tfs_seen;
		logic fsr_q;
		logic fst_q;
		logic [4:0] rx_cnt_q;
		logic [15:0] rx_sh_q;
		logic [4:0] slot_q;
		logic mc_run_q;
		logic [4:0] slast;
		logic mc_cont;
		logic rx_go;
		logic rx_now;
		logic rx_done;
		logic rx_keep;
		logic [15:0] rx_word;
		logic [15:0] rx_data;
		logic buf_ready;
		logic [AB_W-1:0] rx_ab_q;
		logic rx_ab_wrap;
		logic [4:0] tx_cnt_q;
		logic [15:0] tx_sh_q;
		logic [15:0] tx_buf_q;
		logic tx_full_q;
		logic tx_go;
		logic tx_load;
		logic [4:0] tx_slot;
		logic tx_sel;
		logic [15:0] tx_data;
		logic tx_done;
		logic dt_q;
		logic drv_q;
		logic [AB_W-1:0] tx_ab_q;
		logic tx_ab_wrap;
		logic rx_irq_q;
		logic tx_irq_q;
		logic ovr_q;

		assign c = cfg_i[p];
		assign alt = (p == 1) && p1_alt_i;
		assign en = !alt;
		assign mc = (p == 0) && mc_en_i;
		assign slen = (c.slen < SLEN_MIN) ? SLEN_MIN : c.slen;
		assign mask = 16'hffff >> (SLEN_MAX - slen);

		// Internal serial clock divider, kept running in alternate mode
		assign tick = (dcnt_q == c.sclk_div);
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				dcnt_q <= DIV_RST;
				sck_q <= 1'b0;
			end else if (tick) begin
				dcnt_q <= DIV_RST;
				sck_q <= !sck_q;
			end else begin
				dcnt_q <= dcnt_q + 1'b1;
			end
		end

		// Edge enables from internal or external clock
		assign rise = c.int_sclk ? (tick && !sck_q) : (s2_q[p].sclk && !sck_s3_q[p]);
		assign fall = c.int_sclk ? (tick && sck_q) : (!s2_q[p].sclk && sck_s3_q[p]);

		assign rfs_seen = c.rx_fs_int ? fsr_q : (s2_q[p].rfs ^ c.fs_inv);
		assign tfs_seen = c.tx_fs_int ? fst_q : (s2_q[p].tfs ^ c.fs_inv);

		// Receive section
		assign slast = mc_32_i ? MC_LAST_32 : MC_LAST_24;
		assign mc_cont = mc && mc_run_q && (slot_q != slast);
		assign rx_go = rise && en && (rx_cnt_q == CNT_RST)
			&& (!c.rx_fs_en || rfs_seen || mc_cont);
		assign rx_now = !c.rx_fs_en || c.fs_alt || (mc_cont && !rfs_seen);
		assign rx_done = rise && en && (rx_cnt_q == 5'h01);

		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				rx_cnt_q <= CNT_RST;
				rx_sh_q <= '0;
			end else if (rise && en) begin
				if (rx_cnt_q != CNT_RST) begin
					rx_sh_q <= {rx_sh_q[14:0], s2_q[p].dr};
					rx_cnt_q <= rx_cnt_q - 5'h01;
				end else if (rx_go && rx_now) begin
					rx_sh_q <= {rx_sh_q[14:0], s2_q[p].dr};
					rx_cnt_q <= {1'b0, slen};
				end else if (rx_go) begin
					rx_cnt_q <= {1'b0, slen} + 5'h01;
				end
			end
		end

		// Internal receive sync, changed on falling edges
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) fsr_q <= 1'b0;
			else if (fall) begin
				fsr_q <= c.rx_fs_en && c.rx_fs_int && en && !mc_cont
					&& (c.fs_alt ? (rx_cnt_q != 5'h01) : (rx_cnt_q == CNT_RST));
			end
		end

		// Multichannel slot tracking
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				slot_q <= CNT_RST;
				mc_run_q <= 1'b0;
			end else if (!mc) begin
				mc_run_q <= 1'b0;
			end else if (rx_go) begin
				slot_q <= rfs_seen ? CNT_RST : slot_q + 5'h01;
				if (rfs_seen) mc_run_q <= 1'b1;
			end
		end

		assign rx_keep = !mc || mc_rx_mask_i[slot_q];
		assign rx_word = {rx_sh_q[14:0], s2_q[p].dr} & mask;
		always_comb begin
			case (c.comp)
				COMP_MU: rx_data = mu_expand(rx_word[7:0]);
				COMP_A: rx_data = a_expand(rx_word[7:0]);
				default: rx_data = rx_word;
			endcase
		end

		// Receive holding stage; second word slot absorbs a core stall
		dssp_fifo #(
			.W(WORD_W),
			.DEPTH(RX_BUF_DEPTH)
		) u_rx_buf (
			.clk_i(clk_i),
			.sys_rst_i(sys_rst_i),
			.in_valid_i(rx_done && rx_keep),
			.in_ready_o(buf_ready),
			.in_data_i(rx_data),
			.out_valid_o(rx_valid_o[p]),
			.out_ready_i(rx_ready_i[p]),
			.out_data_o(rx_data_o[p])
		);

		assign rx_ab_wrap = (rx_ab_q == c.ab_len - 1'b1);
		always_ff @(posedge clk_i) begin
			if (sys_rst_i || !c.rx_ab_en) rx_ab_q <= '0;
			else if (rx_done && rx_keep) rx_ab_q <= rx_ab_wrap ? '0 : rx_ab_q + 1'b1;
		end

		// Transmit section
		assign tx_slot = (rx_cnt_q == CNT_RST) ? CNT_RST : slot_q + 5'h01;
		assign tx_sel = !mc || mc_tx_mask_i[tx_slot];
		assign tx_go = mc
			? (rise && en && (((rx_cnt_q == CNT_RST) && rfs_seen)
				|| ((rx_cnt_q == 5'h01) && mc_cont)))
			: (rise && en && (tx_cnt_q == CNT_RST) && (!c.tx_fs_en || tfs_seen
				|| (c.fs_alt && c.tx_fs_int)));
		assign tx_load = tx_go && tx_sel && tx_full_q;
		assign tx_done = fall && (tx_cnt_q == 5'h01);

		always_comb begin
			case (c.comp)
				COMP_MU: tx_data = {8'h00, mu_compress(tx_buf_q)};
				COMP_A: tx_data = {8'h00, a_compress(tx_buf_q)};
				default: tx_data = tx_buf_q;
			endcase
		end

		// Holding register feeds the shifter
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				tx_full_q <= 1'b0;
				tx_buf_q <= '0;
			end else if (tx_load) begin
				tx_full_q <= 1'b0;
			end else if (tx_valid_i[p] && !tx_full_q && en) begin
				tx_buf_q <= tx_data_i[p];
				tx_full_q <= 1'b1;
			end
		end

		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				tx_cnt_q <= CNT_RST;
				tx_sh_q <= '0;
				dt_q <= 1'b0;
				drv_q <= 1'b0;
			end else if (tx_load) begin
				tx_sh_q <= tx_data << (SLEN_MAX - slen);
				tx_cnt_q <= {1'b0, slen} + 5'h01;
			end else if (fall) begin
				if (tx_cnt_q != CNT_RST) begin
					dt_q <= tx_sh_q[15];
					tx_sh_q <= {tx_sh_q[14:0], 1'b0};
					tx_cnt_q <= tx_cnt_q - 5'h01;
					drv_q <= 1'b1;
				end else begin
					drv_q <= 1'b0;
				end
			end
		end

		// Internal transmit sync
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) fst_q <= 1'b0;
			else if (fall) begin
				fst_q <= c.tx_fs_en && c.tx_fs_int && en && !mc
					&& (c.fs_alt ? (tx_cnt_q != CNT_RST)
						: ((tx_cnt_q == CNT_RST) && tx_full_q));
			end
		end

		assign tx_ab_wrap = (tx_ab_q == c.ab_len - 1'b1);
		always_ff @(posedge clk_i) begin
			if (sys_rst_i || !c.tx_ab_en) tx_ab_q <= '0;
			else if (tx_done) tx_ab_q <= tx_ab_wrap ? '0 : tx_ab_q + 1'b1;
		end

		// Word and buffer interrupts, one-cycle pulses
		always_ff @(posedge clk_i) begin
			if (sys_rst_i) begin
				rx_irq_q <= 1'b0;
				tx_irq_q <= 1'b0;
				ovr_q <= 1'b0;
			end else begin
				rx_irq_q <= rx_done && rx_keep && (!c.rx_ab_en || rx_ab_wrap);
				tx_irq_q <= tx_done && (!c.tx_ab_en || tx_ab_wrap);
				ovr_q <= rx_done && rx_keep && !buf_ready;
			end
		end

		assign rx_irq_o[p] = rx_irq_q;
		assign tx_irq_o[p] = tx_irq_q;
		assign rx_overrun_o[p] = ovr_q;
		assign tx_ready_o[p] = !tx_full_q && en;

		assign pin_o[p] = '{
			sclk: sck_q,
			sclk_oe_n: !c.int_sclk,
			rfs: fsr_q ^ c.fs_inv,
			rfs_oe_n: alt || !(c.rx_fs_en && c.rx_fs_int),
			tfs: fst_q ^ c.fs_inv,
			tfs_oe_n: alt || !(c.tx_fs_en && c.tx_fs_int),
			dt: alt ? flag_out_q : dt_q,
			dt_oe_n: alt ? 1'b0 : !drv_q
		};
	end

endmodule : dssp_top

// ==== include/dssp_pkg.sv ====
// Purpose: Shared types, constants and compander functions for the serial port pair
// Assumes: 16-bit core words, 100 MHz system clock
// Notes: Compander works on right-justified 14-bit (mu) or 13-bit (A) linear data
package dssp_pkg;

	localparam int PORTS = 2;
	localparam int WORD_W = 16;
	localparam int DIV_W = 16;
	localparam int AB_W = 14;
	localparam int RX_BUF_DEPTH = 2;
	localparam logic [3:0] SLEN_MIN = 4'h2;
	localparam logic [3:0] SLEN_MAX = 4'hf;
	localparam logic [4:0] MC_LAST_24 = 5'h17;
	localparam logic [4:0] MC_LAST_32 = 5'h1f;
	localparam logic [4:0] CNT_RST = 5'h00;
	localparam logic [DIV_W-1:0] DIV_RST = 16'h0000;
	localparam logic [13:0] MU_BIAS = 14'h0021;
	localparam logic [13:0] MU_CLIP = 14'h1fff;
	localparam logic [11:0] A_CLIP = 12'hfff;
	localparam logic [7:0] A_XOR = 8'h55;

	typedef enum logic [1:0] {
		COMP_NONE = 2'b00,
		COMP_RSVD = 2'b01,
		COMP_MU = 2'b10,
		COMP_A = 2'b11
	} dssp_comp_t;

	typedef struct packed {
		logic int_sclk;
		logic rx_fs_en;
		logic rx_fs_int;
		logic tx_fs_en;
		logic tx_fs_int;
		logic fs_inv;
		logic fs_alt;
		logic [3:0] slen;
		dssp_comp_t comp;
		logic [DIV_W-1:0] sclk_div;
		logic rx_ab_en;
		logic tx_ab_en;
		logic [AB_W-1:0] ab_len;
	} dssp_cfg_t;

	typedef struct packed {
		logic sclk;
		logic rfs;
		logic tfs;
		logic dr;
	} dssp_pin_in_t;

	typedef struct packed {
		logic sclk;
		logic sclk_oe_n;
		logic rfs;
		logic rfs_oe_n;
		logic tfs;
		logic tfs_oe_n;
		logic dt;
		logic dt_oe_n;
	} dssp_pin_out_t;

	function automatic logic [7:0] mu_compress(input logic [15:0] x);
		logic s;
		logic [13:0] m;
		logic [2:0] seg;
		s = x[15];
		m = s ? 14'(~x[13:0] + 14'h0001) : x[13:0];
		m = (m > MU_CLIP - MU_BIAS) ? MU_CLIP : m + MU_BIAS;
		seg = 3'h0;
		for (int i = 6; i <= 12; i++) begin
			if (m[i]) seg = 3'(i - 5);
		end
		mu_compress = ~{s, seg, 4'(m >> ({1'b0, seg} + 4'h1))};
	endfunction : mu_compress

	function automatic logic [15:0] mu_expand(input logic [7:0] c);
		logic [7:0] u;
		logic [15:0] v;
		u = ~c;
		v = {2'b00, 14'(((14'({u[3:0], 1'b1}) + 14'h0020) << u[6:4]) - MU_BIAS)};
		mu_expand = u[7] ? 16'(~v + 16'h0001) : v;
	endfunction : mu_expand

	function automatic logic [7:0] a_compress(input logic [15:0] x);
		logic [12:0] a;
		logic [11:0] m;
		logic [2:0] seg;
		a = x[15] ? 13'(~x[12:0] + 13'h0001) : x[12:0];
		m = a[12] ? A_CLIP : a[11:0];
		seg = 3'h0;
		for (int i = 5; i <= 11; i++) begin
			if (m[i]) seg = 3'(i - 4);
		end
		a_compress = {~x[15], seg, (seg == 3'h0) ? m[4:1] : 4'(m >> seg)} ^ A_XOR;
	endfunction : a_compress

	function automatic logic [15:0] a_expand(input logic [7:0] c);
		logic [7:0] u;
		logic [12:0] m;
		logic [15:0] v;
		u = c ^ A_XOR;
		if (u[6:4] == 3'h0) m = 13'({u[3:0], 1'b1});
		else m = (13'({u[3:0], 1'b1}) + 13'h0020) << (u[6:4] - 3'h1);
		v = {3'b000, m};
		a_expand = u[7] ? v : 16'(~v + 16'h0001);
	endfunction : a_expand

endpackage : dssp_pkg

// ==== logic/dssp_fifo.sv ====
// Purpose: Small word buffer with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Depth and width are parameters; default depth two
`timescale 1ns/1ps
module dssp_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 2
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
	localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] cnt_q;
	logic push;
	logic pop;

	assign in_ready_o = (cnt_q != FULL);
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem_q[rd_q];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) mem_q[wr_q] <= in_data_i;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) wr_q <= (wr_q == LAST) ? '0 : wr_q + 1'b1;
			if (pop) rd_q <= (rd_q == LAST) ? '0 : rd_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) cnt_q <= '0;
		else if (push && !pop) cnt_q <= cnt_q + 1'b1;
		else if (pop && !push) cnt_q <= cnt_q - 1'b1;
	end

endmodule : dssp_fifo

// ==== tb/dssp_top_monitor.sv ====
// Purpose: Port-level assertions for the serial port pair
// Assumes: Bound to dssp_top, one clock domain
// Notes: Port one checks cover the alternate pin function
`timescale 1ns/1ps
module dssp_top_monitor import dssp_pkg::*; (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire dssp_cfg_t [PORTS-1:0] cfg_i,
	input wire dssp_pin_out_t [PORTS-1:0] pin_o,
	input wire logic [PORTS-1:0] tx_valid_i,
	input wire logic [PORTS-1:0] tx_ready_o,
	input wire logic [PORTS-1:0] rx_valid_o,
	input wire logic [PORTS-1:0][WORD_W-1:0] rx_data_o,
	input wire logic [PORTS-1:0] rx_ready_i,
	input wire logic [PORTS-1:0] rx_irq_o,
	input wire logic [PORTS-1:0] rx_overrun_o,
	input wire logic p1_alt_i,
	input wire logic flag_output_i,
	input wire logic ext_interrupt_a_o,
	input wire logic ext_interrupt_b_o,
	input wire logic flag_input_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);

	// Two cycles in one pin function
	sequence alt_two;
		p1_alt_i ##1 p1_alt_i;
	endsequence
	sequence core_two;
		!p1_alt_i ##1 !p1_alt_i;
	endsequence

	rx_irq_word_a: assert property (rx_irq_o[0] |-> rx_valid_o[0])
		else $error("receive interrupt without a word");
	tx_take_a: assert property (tx_valid_i[0] && tx_ready_o[0] |=> !tx_ready_o[0])
		else $error("holding register not marked full");
	rx_hold_a: assert property (rx_valid_o[0] && !rx_ready_i[0] |=>
		rx_valid_o[0] && $stable(rx_data_o[0]))
		else $error("receive word lost while stalled");
	overrun_full_a: assert property (rx_overrun_o[0] |-> rx_valid_o[0])
		else $error("overrun with room in buffer");
	sclk_dir_a: assert property ($stable(cfg_i[0].int_sclk) |=>
		pin_o[0].sclk_oe_n == !$past(cfg_i[0].int_sclk))
		else $error("serial clock direction wrong");
	alt_ready_a: assert property (alt_two |-> !tx_ready_o[1])
		else $error("port one accepts words in flag mode");
	flag_out_a: assert property (alt_two |->
		pin_o[1].dt == $past(flag_output_i) && !pin_o[1].dt_oe_n)
		else $error("flag output not on data pin");
	core_quiet_a: assert property (core_two |->
		!ext_interrupt_a_o && !ext_interrupt_b_o && !flag_input_o)
		else $error("flag outputs active in serial mode");
endmodule : dssp_top_monitor

bind dssp_top dssp_top_monitor u_mon (.clk_i, .sys_rst_i, .cfg_i, .pin_o, .tx_valid_i,
	.tx_ready_o, .rx_valid_o, .rx_data_o, .rx_ready_i, .rx_irq_o, .rx_overrun_o, .p1_alt_i,
	.flag_output_i, .ext_interrupt_a_o, .ext_interrupt_b_o, .flag_input_o);

// ==== tb/dssp_link_model.sv ====
// Purpose: Far-side serial device for port one
// Assumes: Link clock 160 ns, made only within frames
// Notes: Data line shows the inverse of the last bit once released
`timescale 1ns/1ps
module dssp_link_model import dssp_pkg::*; (
	input wire dssp_pin_out_t dev_i,
	output dssp_pin_in_t link_o
);
	initial link_o = '0;

	// One framed word each way, syncs driven here
	task automatic frame(input logic [15:0] w, input int n, output logic [15:0] got);
		got = '0;
		#3;
		link_o.rfs = 1'b1;
		link_o.tfs = 1'b1;
		#80 link_o.sclk = 1'b1;
		for (int i = n - 1; i >= 0; i--) begin
			#80 link_o.sclk = 1'b0;
			link_o.rfs = 1'b0;
			link_o.tfs = 1'b0;
			link_o.dr = w[i];
			#80 link_o.sclk = 1'b1;
			got = {got[14:0], dev_i.dt};
		end
		#80 link_o.sclk = 1'b0;
		link_o.dr = ~link_o.dr;
	endtask : frame
endmodule : dssp_link_model

// ==== tb/dssp_top_tb.sv ====
// Purpose: Self-checking bench for the serial port pair
// Assumes: Port zero looped back on itself, port one faces the link model
// Notes: Multichannel inputs held off
`timescale 1ns/1ps
module dssp_top_tb import dssp_pkg::*;;
	logic clk, rst, p1_alt, flag_out, ext_a, ext_b, flag_in;
	logic [2:0] lvl;
	dssp_cfg_t [1:0] cfg;
	wire dssp_pin_in_t [1:0] pin_in;
	dssp_pin_out_t [1:0] pin_out;
	dssp_pin_in_t link;
	logic [1:0] tx_valid, tx_ready, rx_valid, rx_ready, rx_irq, tx_irq, ovr;
	logic [1:0][15:0] tx_data, rx_data;
	int n_mismatch, n_checks, n_txirq, n_ovr, n_rxirq;

	assign pin_in[0] = {pin_out[0].sclk, pin_out[0].tfs, pin_out[0].tfs,
		pin_out[0].dt ^ pin_out[0].dt_oe_n};
	assign pin_in[1] = p1_alt ? {1'b0, lvl} : link;

	dssp_top u_dut (.clk_i(clk), .sys_rst_i(rst), .cfg_i(cfg), .pin_i(pin_in), .pin_o(pin_out),
		.tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready),
		.rx_valid_o(rx_valid), .rx_data_o(rx_data), .rx_ready_i(rx_ready),
		.rx_irq_o(rx_irq), .tx_irq_o(tx_irq), .rx_overrun_o(ovr), .mc_en_i(1'b0),
		.mc_32_i(1'b0), .mc_rx_mask_i(32'h0), .mc_tx_mask_i(32'h0), .p1_alt_i(p1_alt),
		.flag_output_i(flag_out), .ext_interrupt_a_o(ext_a), .ext_interrupt_b_o(ext_b),
		.flag_input_o(flag_in));
	dssp_link_model u_link (.dev_i(pin_out[1]), .link_o(link));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (tx_irq[0] === 1'b1) n_txirq++;
		if (ovr[0] === 1'b1) n_ovr++;
		if (rx_irq[0] === 1'b1) n_rxirq++;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic push(input int p, input logic [15:0] d);
		@(negedge clk);
		tx_data[p] = d;
		tx_valid[p] = 1'b1;
		while (tx_ready[p] !== 1'b1) @(negedge clk);
		@(negedge clk);
		tx_valid[p] = 1'b0;
	endtask : push

	task automatic pop(input int p, input logic [15:0] e);
		while (rx_valid[p] !== 1'b1) @(negedge clk);
		chk(rx_data[p], e);
		rx_ready[p] = 1'b1;
		@(negedge clk);
		rx_ready[p] = 1'b0;
		@(negedge clk);
	endtask : pop

	// Three words queued with the receiver stalled
	task automatic t_loop();
		push(0, 16'ha5c3);
		push(0, 16'h3c5a);
		push(0, 16'h0f0f);
		while (n_ovr == 0) @(negedge clk);
		chk(16'(n_ovr), 16'h0001);
		pop(0, 16'ha5c3);
		pop(0, 16'h3c5a);
		chk(16'(n_txirq), 16'h0003);
	endtask : t_loop

	// Values on a segment step survive compress and expand
	task automatic t_comp();
		cfg[0].slen = 4'h7;
		cfg[0].comp = COMP_MU;
		push(0, 16'h0137);
		pop(0, 16'h0137);
		cfg[0].comp = COMP_A;
		push(0, 16'h02b0);
		pop(0, 16'h02b0);
	endtask : t_comp

	// Two-word autobuffer on port zero, one interrupt per buffer each way
	task automatic t_abuf();
		int rx0;
		int tx0;
		rx0 = n_rxirq;
		tx0 = n_txirq;
		cfg[0].comp = COMP_NONE;
		cfg[0].rx_ab_en = 1'b1;
		cfg[0].tx_ab_en = 1'b1;
		cfg[0].ab_len = 14'h0002;
		push(0, 16'h1255);
		push(0, 16'h00aa);
		pop(0, 16'h0055);
		pop(0, 16'h00aa);
		chk(16'(n_rxirq - rx0), 16'h0001);
		chk(16'(n_txirq - tx0), 16'h0001);
		cfg[0].rx_ab_en = 1'b0;
		cfg[0].tx_ab_en = 1'b0;
	endtask : t_abuf

	// External clock and syncs at three word lengths
	task automatic t_ext();
		int len[3] = '{3, 8, 16};
		logic [15:0] got;
		logic [15:0] m;
		for (int i = 0; i < 3; i++) begin
			m = 16'hffff >> (16 - len[i]);
			cfg[1].slen = 4'(len[i] - 1);
			push(1, 16'hc3a5);
			u_link.frame(16'h5a3c, len[i], got);
			chk(got, 16'hc3a5 & m);
			pop(1, 16'h5a3c & m);
		end
	endtask : t_ext

	// Port one pins as interrupts and flags, then back
	task automatic t_alt();
		lvl = 3'b101;
		flag_out = 1'b1;
		p1_alt = 1'b1;
		repeat (6) @(negedge clk);
		chk({ext_a, ext_b, flag_in, pin_out[1].dt, pin_out[1].dt_oe_n, tx_ready[1]}, 16'h2c);
		lvl = 3'b010;
		flag_out = 1'b0;
		repeat (6) @(negedge clk);
		chk({ext_a, ext_b, flag_in, pin_out[1].dt, pin_out[1].dt_oe_n, tx_ready[1]}, 16'h10);
		p1_alt = 1'b0;
		repeat (6) @(negedge clk);
		chk({ext_a, ext_b, flag_in, tx_ready[1]}, 16'h1);
	endtask : t_alt

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		test_done();
	end

	initial begin
		{rst, p1_alt, flag_out, lvl} = 6'h20;
		{tx_valid, rx_ready, tx_data} = '0;
		cfg = '0;
		cfg[0].int_sclk = 1'b1;
		cfg[0].rx_fs_en = 1'b1;
		cfg[0].tx_fs_en = 1'b1;
		cfg[0].tx_fs_int = 1'b1;
		cfg[0].slen = 4'hf;
		cfg[0].sclk_div = 16'h0007;
		cfg[1].rx_fs_en = 1'b1;
		cfg[1].tx_fs_en = 1'b1;
		repeat (16) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		chk({tx_ready, rx_valid, pin_out[0].dt_oe_n, pin_out[1].sclk_oe_n}, 16'h33);
		t_loop();
		t_comp();
		t_abuf();
		t_ext();
		t_alt();
		test_done();
	end
endmodule : dssp_top_tb
